// ==== shared/t4tah_pkg.sv ====
package t4tah_pkg;

  // ==========================================================================
  // Command header bytes
  // ==========================================================================
  localparam logic [7:0]  CLA_T4T        = 8'h00;
  localparam logic [7:0]  INS_SELECT     = 8'hA4;
  localparam logic [7:0]  INS_READ_BIN   = 8'hB0;
  localparam logic [7:0]  INS_UPDATE_BIN = 8'hD6;
  localparam logic [7:0]  P1_SEL_NAME    = 8'h04;
  localparam logic [7:0]  P1_SEL_FILE    = 8'h00;

  // ==========================================================================
  // Status words
  // ==========================================================================
  localparam logic [15:0] SW_OK          = 16'h9000;
  localparam logic [15:0] SW_NOT_FOUND   = 16'h6A82;
  localparam logic [15:0] SW_NO_FILE     = 16'h6982;
  localparam logic [15:0] SW_WRONG_PARAM = 16'h6A86;
  localparam logic [15:0] SW_BAD_CLASS   = 16'h6E00;
  localparam logic [15:0] SW_BAD_INS     = 16'h6D00;

  // ==========================================================================
  // Files and access values
  // ==========================================================================
  localparam logic [15:0] FID_CC         = 16'hE103;
  localparam logic [15:0] FID_DATA       = 16'hE104;
  localparam logic [7:0]  WR_FULL        = 8'h00;
  localparam logic [7:0]  WR_NONE        = 8'hFF;
  localparam logic [7:0]  LC_CC_UPDATE   = 8'h01;
  localparam logic [7:0]  WR_ACC_RESET   = 8'h00;
  localparam int          CC_LEN         = 15;
  localparam int          CC_WR_IDX      = 14;
  localparam int          AID_LEN        = 7;
  localparam logic [55:0] AID_VALUE      = 56'hD2_7600_0085_0101;

endpackage

// ==== rtl/t4tah_store.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Byte store for the data file, one write and one read port
// ============================================================================
module t4tah_store #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  logic [7:0] mem_r [DEPTH];

  // Write port
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Asynchronous read
  assign o_rdata = mem_r[i_raddr];

endmodule

`default_nettype wire

// ==== rtl/t4tah_core.sv ====
`timescale 1ns/1ps
`default_nettype none


// ============================================================================
// Command interpreter for an emulated Type 4 tag
// ============================================================================
module t4tah_core
  import t4tah_pkg::*;
#(
  parameter int MAX_FILE = 255,
  parameter int AW       = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_byte,
  input  wire logic       i_cmd_last,
  input  wire logic       i_rsp_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_byte,
  output logic            o_rsp_last,
  output logic            o_busy,
  output logic            o_app_sel,
  output logic            o_file_sel
);
  import t4tah_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_RX   = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SW   = 4'b1000
  } t4tah_state_e;

  t4tah_state_e state_r;
  logic [7:0]  hdr_r [5];         // CLA INS P1 P2 P3
  logic [8:0]  cnt_r;             // Bytes received, room for Lc 255 plus header
  logic [7:0]  body_r [8];        // Short data for select ids
  logic        app_sel_r;
  logic [1:0]  file_r;            // 0 none, 1 container, 2 data
  logic [7:0]  wr_acc_r;
  logic [7:0]  flen_r;            // Stored data length
  logic [15:0] sw_r;
  logic [7:0]  tx_idx_r;
  logic [7:0]  tx_len_r;
  logic        sw_lo_r;
  logic        upd_ok_r;          // Update allowed, data may be stored
  logic        rsp_valid_r;
  logic [7:0]  rsp_byte_r;
  logic        rsp_last_r;
  logic        rsp_end_r;         // Final status byte on the output

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic [7:0] cla     = hdr_r[0];
  wire logic [7:0] ins     = hdr_r[1];
  wire logic [7:0] p1      = hdr_r[2];
  wire logic [7:0] p3      = hdr_r[4];
  wire logic       cla_ok  = (cla == CLA_T4T);
  wire logic [15:0] fid    = {body_r[0], body_r[1]};
  wire logic       aid_hit = (p3 == 8'(AID_LEN)) &&
                             ({body_r[0], body_r[1], body_r[2], body_r[3],
                               body_r[4], body_r[5], body_r[6]} == AID_VALUE);
  wire logic       fid_cc  = (p3 == 8'h02) && (fid == FID_CC);
  wire logic       fid_dat = (p3 == 8'h02) && (fid == FID_DATA);
  wire logic       wr_perm = (file_r == 2'd2) ? (wr_acc_r == WR_FULL)
                                              : (wr_acc_r != WR_NONE);
  wire logic [7:0] cur_len = (file_r == 2'd1) ? 8'(CC_LEN) : flen_r;
  wire logic       rx_take = (state_r == ST_RX) && i_cmd_valid;
  wire logic       in_body = rx_take && (cnt_r >= 9'd5);
  wire logic [7:0] body_ix = 8'(cnt_r - 9'd5);
  wire logic       tx_go   = rsp_valid_r && i_rsp_ready;

  // Capability container image, privilege byte live
  function automatic logic [7:0] cc_byte(input logic [7:0] idx, input logic [7:0] wacc);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      8'd1:    b = 8'(CC_LEN);
      8'd2:    b = 8'h20;
      8'd4:    b = 8'hFB;
      8'd6:    b = 8'hF9;
      8'd7:    b = 8'h04;
      8'd8:    b = 8'h06;
      8'd9:    b = FID_DATA[15:8];
      8'd10:   b = FID_DATA[7:0];
      8'd12:   b = 8'(MAX_FILE);
      8'd14:   b = wacc;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // Data file store
  // ==========================================================================
  wire logic       st_we  = in_body && upd_ok_r && (file_r == 2'd2);
  wire logic [7:0] st_rd;

  t4tah_store #(
    .DEPTH (256),
    .AW    (AW)
  ) u_store (
    .i_clk   (i_clk),
    .i_we    (st_we),
    .i_waddr (body_ix[AW-1:0]),
    .i_wdata (i_cmd_byte),
    .i_raddr (tx_idx_r[AW-1:0]),
    .o_rdata (st_rd)
  );

  // ==========================================================================
  // Command execution: status and outcome
  // ==========================================================================
  logic [15:0] ex_sw;
  logic [7:0]  ex_len;
  always_comb
  begin
    ex_sw  = SW_OK;
    ex_len = 8'd0;
    if (!cla_ok)
      ex_sw = SW_BAD_CLASS;
    else if (ins == INS_SELECT)
    begin
      if (p1 == P1_SEL_NAME)
        ex_sw = aid_hit ? SW_OK : SW_NOT_FOUND;
      else if (p1 == P1_SEL_FILE)
        ex_sw = (app_sel_r && (fid_cc || fid_dat)) ? SW_OK : SW_NOT_FOUND;
      else
        ex_sw = SW_WRONG_PARAM;
    end
    else if (ins == INS_READ_BIN)
    begin
      if (file_r == 2'd0)
        ex_sw = SW_NO_FILE;
      else if (p3 > cur_len)
        ex_sw = SW_WRONG_PARAM;
      else
        ex_len = p3;
    end
    else if (ins == INS_UPDATE_BIN)
      ex_sw = upd_ok_r ? SW_OK : ((file_r == 2'd0) ? SW_NO_FILE : SW_WRONG_PARAM);
    else
      ex_sw = SW_BAD_INS;
  end

  // Update gate judged once the header is complete
  wire logic upd_gate = (file_r != 2'd0) && wr_perm &&
                        ((file_r == 2'd1) ? (i_cmd_byte == LC_CC_UPDATE)
                                          : (i_cmd_byte <= 8'(MAX_FILE)));

  // ==========================================================================
  // Receive counters and header capture
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r    <= 9'd0;
      upd_ok_r <= 1'b0;
    end
    else if (rx_take)
    begin
      cnt_r    <= i_cmd_last ? 9'd0 : cnt_r + 9'd1;
      if (cnt_r == 9'd4)
        upd_ok_r <= (hdr_r[1] == INS_UPDATE_BIN) && (hdr_r[0] == CLA_T4T) && upd_gate;
    end
    else if (state_r == ST_SW && tx_go && sw_lo_r)
      upd_ok_r <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (rx_take && cnt_r < 9'd5)
      hdr_r[cnt_r[2:0]] <= i_cmd_byte;
    if (in_body && body_ix < 8'd8)
      body_r[body_ix[2:0]] <= i_cmd_byte;
  end

  // ==========================================================================
  // Selection and file state
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      app_sel_r <= 1'b0;
      file_r    <= 2'd0;
      wr_acc_r  <= WR_ACC_RESET;
      flen_r    <= 8'd0;
    end
    else if (state_r == ST_EXEC && cla_ok && ins == INS_SELECT)
    begin
      if (p1 == P1_SEL_NAME)
      begin
        app_sel_r <= aid_hit;
        file_r    <= 2'd0;
      end
      else if (p1 == P1_SEL_FILE && app_sel_r)
        file_r <= fid_cc ? 2'd1 : (fid_dat ? 2'd2 : 2'd0);
    end
    else if (state_r == ST_EXEC && upd_ok_r)
    begin
      if (file_r == 2'd1)
        wr_acc_r <= body_r[0];
      else
        flen_r <= p3;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_r <= ST_RX;
    else
    begin
      unique case (state_r)
        ST_RX:   if (rx_take && i_cmd_last) state_r <= ST_EXEC;
        ST_EXEC: state_r <= (ex_len != 8'd0) ? ST_DATA : ST_SW;
        ST_DATA: if (tx_go && rsp_last_r) state_r <= ST_SW;
        ST_SW:   if (tx_go && sw_lo_r) state_r <= ST_RX;
        default: state_r <= ST_RX;
      endcase
    end
  end

  // ==========================================================================
  // Response output: data bytes, then status word
  // ==========================================================================
  wire logic [7:0] data_b = (file_r == 2'd1) ? cc_byte(tx_idx_r, wr_acc_r) : st_rd;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sw_r        <= SW_OK;
      tx_idx_r    <= 8'd0;
      tx_len_r    <= 8'd0;
      sw_lo_r     <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_byte_r  <= 8'h00;
      rsp_last_r  <= 1'b0;
      rsp_end_r   <= 1'b0;
    end
    else if (state_r == ST_EXEC)
    begin
      sw_r     <= ex_sw;
      tx_idx_r <= 8'd0;
      tx_len_r <= ex_len;
      sw_lo_r  <= 1'b0;
    end
    else if (state_r == ST_DATA && (!rsp_valid_r || tx_go) && !(tx_go && rsp_last_r))
    begin
      rsp_valid_r <= 1'b1;
      rsp_byte_r  <= data_b;
      rsp_last_r  <= (tx_idx_r + 8'd1 == tx_len_r);
      tx_idx_r    <= tx_idx_r + 8'd1;
    end
    else if (state_r == ST_SW)
    begin
      // High status byte first, low byte marked as the end of the reply
      if (!rsp_valid_r)
      begin
        rsp_valid_r <= 1'b1;
        rsp_byte_r  <= sw_r[15:8];
      end
      else if (tx_go && !sw_lo_r)
      begin
        rsp_byte_r  <= sw_r[7:0];
        sw_lo_r     <= 1'b1;
        rsp_end_r   <= 1'b1;
      end
      else if (tx_go)
      begin
        rsp_valid_r <= 1'b0;
        rsp_end_r   <= 1'b0;
      end
    end
    else if (tx_go)
    begin
      rsp_valid_r <= 1'b0;
      rsp_last_r  <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_rsp_valid = rsp_valid_r;
  assign o_rsp_byte  = rsp_byte_r;
  assign o_rsp_last  = rsp_end_r;
  assign o_busy      = (state_r != ST_RX);
  assign o_app_sel   = app_sel_r;
  assign o_file_sel  = (file_r != 2'd0);

endmodule

`default_nettype wire

// ==== sim/t4tah_chk_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Port checker for the command interpreter
// ============================================================================
module t4tah_chk
  import t4tah_pkg::*;
#(
  parameter int MAX_FILE = 255
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic       i_cmd_last,
  input wire logic       i_rsp_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire logic       o_rsp_last,
  input wire logic       o_busy,
  input wire logic       o_app_sel,
  input wire logic       o_file_sel
);
  logic [7:0]  idx_r, cla_r, ins_r, p1_r, p3_r, hi_r, n_r;
  logic        fs_r;
  wire logic        tc = i_cmd_valid && !o_busy;
  wire logic        tr = o_rsp_valid && i_rsp_ready;
  wire logic        te = tr && o_rsp_last;
  wire logic [15:0] sw = {hi_r, o_rsp_byte};

  // Header capture and response byte count
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      {idx_r, cla_r, ins_r, p1_r, p3_r, hi_r, n_r, fs_r} <= '0;
    end
    else
    begin
      if (tc) idx_r <= i_cmd_last ? 8'h00 : idx_r + 8'h01;
      if (tc && idx_r == 8'h00) cla_r <= i_cmd_byte;
      if (tc && idx_r == 8'h00) fs_r <= o_file_sel;
      if (tc && idx_r == 8'h01) ins_r <= i_cmd_byte;
      if (tc && idx_r == 8'h02) p1_r <= i_cmd_byte;
      if (tc && idx_r == 8'h04) p3_r <= i_cmd_byte;
      if (tr) n_r <= o_rsp_last ? 8'h00 : n_r + 8'h01;
      if (tr) hi_r <= o_rsp_byte;
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_bad_class; te && cla_r != CLA_T4T |-> sw == SW_BAD_CLASS; endproperty
  a_bad_class: assert property (p_bad_class) else $error("class not refused");
  property p_no_file; te && !fs_r && cla_r == CLA_T4T
    && (ins_r == INS_READ_BIN || ins_r == INS_UPDATE_BIN) |-> n_r == 8'h01 && sw == SW_NO_FILE;
  endproperty
  a_no_file: assert property (p_no_file) else $error("no-file access answered");
  property p_read_len; te && ins_r == INS_READ_BIN && sw == SW_OK |-> n_r == p3_r + 8'h01;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong");
  property p_app_fsel; o_file_sel |-> o_app_sel; endproperty
  a_app_fsel: assert property (p_app_fsel) else $error("file without application");
  property p_app_rise; $rose(o_app_sel) |-> ins_r == INS_SELECT && p1_r == P1_SEL_NAME;
  endproperty
  a_app_rise: assert property (p_app_rise) else $error("application set by other");
  property p_file_rise; $rose(o_file_sel) |-> ins_r == INS_SELECT && p1_r == P1_SEL_FILE;
  endproperty
  a_file_rise: assert property (p_file_rise) else $error("file set by other");
  property p_hold; o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("response byte dropped");
  property p_answer; tc && i_cmd_last |-> ##[1:16] o_rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no response");
endmodule

bind t4tah_core t4tah_chk #(.MAX_FILE(MAX_FILE)) t4tah_chk_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
  .i_cmd_last(i_cmd_last), .i_rsp_ready(i_rsp_ready), .o_rsp_valid(o_rsp_valid),
  .o_rsp_byte(o_rsp_byte), .o_rsp_last(o_rsp_last), .o_busy(o_busy),
  .o_app_sel(o_app_sel), .o_file_sel(o_file_sel)
);

`default_nettype wire

// ==== sim/t4tah_reader_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Reader side: takes response bytes, stalling when asked
// ============================================================================
module t4tah_reader_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_byte,
  input  wire logic       i_rsp_last,
  input  wire logic       i_slow,
  output logic            o_rsp_ready
);
  logic [7:0] rsp_q[$];
  int         n_done = 0;
  int         ph     = 0;

  // Ready pattern, two stall cycles of three when slow
  always @(negedge i_clk)
  begin
    ph = (ph + 1) % 3;
    o_rsp_ready = !i_slow || (ph == 0);
  end

  // Collect every byte taken by the handshake
  always @(posedge i_clk)
  begin
    if (!i_rst && i_rsp_valid && o_rsp_ready)
    begin
      rsp_q.push_back(i_rsp_byte);
      n_done += i_rsp_last;
    end
  end
endmodule

`default_nettype wire

// ==== sim/type4_tag_apdu_handler_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

// ============================================================================
// Bench for the command interpreter
// ============================================================================
module type4_tag_apdu_handler_tb_top;
  import t4tah_pkg::*;
  typedef logic [7:0] t4tah_q_t[$];
  localparam int MF = 8;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       cv   = 1'b0;
  logic [7:0] cb   = 8'h00;
  logic       cl   = 1'b0;
  logic       slow = 1'b0;
  wire logic  rv, rl, rdy, busy, app, fil;
  wire logic [7:0] rb;
  int         failures   = 0;
  int         num_checks = 0;

  // Clock and watchdog
  initial forever #2.5 clk = ~clk;
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    give_verdict;
  end

  t4tah_core #(.MAX_FILE(MF)) t4tah_core_i (
    .i_clk(clk), .i_rst(rst), .i_cmd_valid(cv), .i_cmd_byte(cb), .i_cmd_last(cl),
    .i_rsp_ready(rdy), .o_rsp_valid(rv), .o_rsp_byte(rb), .o_rsp_last(rl),
    .o_busy(busy), .o_app_sel(app), .o_file_sel(fil)
  );
  t4tah_reader_model t4tah_reader_model_i (
    .i_clk(clk), .i_rst(rst), .i_rsp_valid(rv), .i_rsp_byte(rb), .i_rsp_last(rl),
    .i_slow(slow), .o_rsp_ready(rdy)
  );

  // ==========================================================================
  // Transfer helpers
  // ==========================================================================
  function automatic logic [7:0] rq(input int i);
    return t4tah_reader_model_i.rsp_q[i];
  endfunction
  function automatic int rn();
    return t4tah_reader_model_i.rsp_q.size();
  endfunction
  function automatic t4tah_q_t aid(input logic [55:0] v);
    t4tah_q_t r;
    for (int i = 6; i >= 0; i--) r.push_back(v[i*8 +: 8]);
    return r;
  endfunction
  task automatic do_reset;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic xfer(input t4tah_q_t c);
    int n;
    n = t4tah_reader_model_i.n_done;
    t4tah_reader_model_i.rsp_q.delete();
    foreach (c[k])
    begin
      @(negedge clk);
      cv = 1'b1;
      cb = c[k];
      cl = (k == c.size() - 1);
    end
    @(negedge clk);
    cv = 1'b0;
    cl = 1'b0;
    for (int w = 0; w < 400 && t4tah_reader_model_i.n_done == n; w++) @(negedge clk);
    for (int w = 0; w < 40 && busy !== 1'b0; w++) @(negedge clk);
    `CHK(t4tah_reader_model_i.n_done, n + 1)
  endtask
  task automatic sw(input logic [15:0] e);
    `CHK({rq(rn() - 2), rq(rn() - 1)}, e)
  endtask
  task automatic sel(input logic [7:0] p1, input t4tah_q_t id, input logic [15:0] e);
    xfer({CLA_T4T, INS_SELECT, p1, 8'h00, 8'(id.size()), id});
    sw(e);
  endtask
  task automatic fsel(input logic [15:0] f, input logic [15:0] e);
    sel(P1_SEL_FILE, {f[15:8], f[7:0]}, e);
  endtask
  task automatic rd(input logic [7:0] le, input logic [15:0] e);
    xfer({CLA_T4T, INS_READ_BIN, 8'h00, 8'h00, le});
    sw(e);
  endtask
  task automatic wr(input t4tah_q_t d, input logic [15:0] e);
    xfer({CLA_T4T, INS_UPDATE_BIN, 8'h00, 8'h00, 8'(d.size()), d});
    sw(e);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_nosel;
    rd(8'h02, SW_NO_FILE);
    `CHK(rn(), 2)
    wr({8'h11}, SW_NO_FILE);
    xfer({CLA_T4T, INS_SELECT, P1_SEL_FILE, 8'h00, 8'h02, 8'hE1, 8'h03});
    sw(SW_NOT_FOUND);
    `CHK(fil, 1'b0)
    xfer({CLA_T4T, 8'h70, 8'h00, 8'h00, 8'h00});
    sw(SW_BAD_INS);
    xfer({8'h80, INS_READ_BIN, 8'h00, 8'h00, 8'h01});
    sw(SW_BAD_CLASS);
  endtask
  task automatic t_select;
    sel(P1_SEL_NAME, aid(AID_VALUE ^ 56'h01), SW_NOT_FOUND);
    `CHK(app, 1'b0)
    sel(P1_SEL_NAME, aid(AID_VALUE), SW_OK);
    `CHK(app, 1'b1)
    sel(8'h02, {8'hE1, 8'h03}, SW_WRONG_PARAM);
    fsel(16'hE105, SW_NOT_FOUND);
    `CHK(fil, 1'b0)
    fsel(FID_CC, SW_OK);
    `CHK(fil, 1'b1)
  endtask
  task automatic t_read;
    rd(8'(CC_LEN), SW_OK);
    `CHK(rn(), CC_LEN + 2)
    `CHK(rq(CC_WR_IDX), WR_ACC_RESET)
    rd(8'(CC_LEN + 1), SW_WRONG_PARAM);
    `CHK(rn(), 2)
    rd(8'h01, SW_OK);
  endtask
  task automatic t_update;
    t4tah_q_t d;
    slow = 1'b1;
    fsel(FID_DATA, SW_OK);
    wr({8'hA1, 8'hB2, 8'hC3}, SW_OK);
    for (int i = 0; i <= MF; i++) d.push_back(8'(i));
    wr(d, SW_WRONG_PARAM);
    rd(8'h03, SW_OK);
    `CHK({rq(0), rq(1), rq(2)}, 24'hA1_B2C3)
    rd(8'h04, SW_WRONG_PARAM);
    d.pop_back();
    wr(d, SW_OK);
    rd(8'(MF), SW_OK);
    `CHK(rq(MF - 1), 8'(MF - 1))
    slow = 1'b0;
  endtask
  task automatic t_priv;
    fsel(FID_CC, SW_OK);
    wr({8'h05, 8'h05}, SW_WRONG_PARAM);
    wr({8'h05}, SW_OK);
    rd(8'(CC_LEN), SW_OK);
    `CHK(rq(CC_WR_IDX), 8'h05)
    fsel(FID_DATA, SW_OK);
    wr({8'h01}, SW_WRONG_PARAM);
    fsel(FID_CC, SW_OK);
    wr({WR_NONE}, SW_OK);
    wr({WR_FULL}, SW_WRONG_PARAM);
    do_reset;
    `CHK({app, fil}, 2'b00)
    sel(P1_SEL_NAME, aid(AID_VALUE), SW_OK);
    fsel(FID_CC, SW_OK);
    rd(8'(CC_LEN), SW_OK);
    `CHK(rq(CC_WR_IDX), WR_FULL)
  endtask

  // Counts and verdict
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    do_reset;
    t_nosel;
    t_select;
    t_read;
    t_update;
    t_priv;
    give_verdict;
  end
endmodule

`default_nettype wire
